// ### verilog/sysclk_consts.svh
`ifndef SYSCLK_CONSTS_SVH
`define SYSCLK_CONSTS_SVH

// register byte addresses
`define SYSCLK_CTRL_ADDR     8'h00
`define FAST_OSC_CTRL_ADDR   8'h04
`define IRQ_STATUS_ADDR      8'h08
`define IRQ_CLEAR_ADDR       8'h0C
`define IRQ_ENABLE_ADDR      8'h10

// system clock control fields
`define SEL_MSB              7
`define SEL_LSB              5
`define HALT_FAST_KEEP_BIT   1
`define HALT_SLOW_KEEP_BIT   0

// fast oscillator control fields
`define FAST_STABLE_BIT      1
`define FAST_ENABLE_BIT      0

// interrupt status layout
`define IRQ_SWITCH_DONE_BIT  0
`define IRQ_FAST_STABLE_BIT  1
`define IRQ_HALT_ENTER_BIT   2
`define IRQ_WIDTH            3

// reset values
`define SEL_RESET            3'h0
`define FAST_KEEP_RESET      1'h0
`define SLOW_KEEP_RESET      1'h0
`define FAST_ENABLE_RESET    1'h1

// select code that picks the sub clock
`define SEL_SUB_CODE         3'h7

// fast divider chain length, reaches divide by 64
`define DIV_WIDTH            6

`endif

// ### verilog/sysclk_pkg.sv
package sysclk_pkg;

    typedef enum logic [4:0] {
        MODE_RUN            = 5'b00001,
        MODE_SLEEP          = 5'b00010,
        MODE_IDLE_SLOW_ONLY = 5'b00100,
        MODE_IDLE_BOTH_OSC  = 5'b01000,
        MODE_IDLE_FAST_ONLY = 5'b10000
    } mode_e;

    typedef enum logic [2:0] {
        SW_RUN   = 3'b001,
        SW_DRAIN = 3'b010,
        SW_ALIGN = 3'b100
    } switch_e;

    typedef struct packed {
        // software visible
        logic [2:0]  sysclk_select;
        logic        halt_fast_osc_keep;
        logic        halt_slow_osc_keep;
        logic        fast_osc_enable;
        logic        fast_osc_stable_flag;
        logic [2:0]  irq_status;
        logic [2:0]  irq_enable;
        // mode and mux
        mode_e       mode;
        switch_e     sw_state;
        logic [2:0]  active_select;
        logic [5:0]  div_count;
        // pin synchronisers and filtered levels
        logic [2:0]  fast_rdy_sync;
        logic        fast_rdy_level;
        logic [2:0]  slow_rdy_sync;
        logic        slow_rdy_level;
        logic [2:0]  slow_clk_sync;
        logic        slow_clk_level;
        // bus
        logic        wr_pend;
        logic        rd_pend;
        logic [7:0]  addr;
        logic [31:0] hrdata;
    } state_s;

endpackage

// ### verilog/system_clock_mode_control.sv
`timescale 1ns/1ps
`include "sysclk_consts.svh"

// What this block does
// - select codes 000..110 give fast clock over 1..64, code 111 gives sub clock
// - halt with both keep bits low enters sleep, stops cpu and sub clock
// - in sleep slow oscillator output runs only while watchdog is enabled
// - halt with fast keep low, slow keep high: slow runs, system clock only on 111
// - halt with both keep bits high keeps both oscillators and system clock running
// - halt with fast keep high, slow keep low: fast runs, system clock off on 111
// - fast keep bit 1 decides if fast oscillator runs while cpu is halted
// - slow keep bit 0 decides if sub clock runs while cpu is halted
// - slow mode runs sub clock from slow oscillator, fast clock follows its enable bit
// - new clock takes effect within four system periods plus source alignment
// - setting fast enable clears stable flag, then sets it once oscillator settles
// - in slow mode, fast enable bit 0 stops fast oscillator, 1 runs it
// - switch to sub clock completes only once slow oscillator is stable
// - unimplemented control bits read as zero
// - halt modes raise state_hold so core logic freezes memory, registers and port states
module system_clock_mode_control (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // cpu and system events, same clock
    input  wire logic        halt_exec,
    input  wire logic        wake_req,
    input  wire logic        wdt_enable,
    // oscillator pins, asynchronous
    input  wire logic        fast_osc_ready,
    input  wire logic        slow_osc_ready,
    input  wire logic        slow_osc_clk,
    // oscillator enables
    output logic             fast_osc_run,
    output logic             slow_osc_run,
    // clock gating and power state
    output logic             cpu_run,
    output logic             system_clock_tick,
    output logic             sub_clock_tick,
    output logic             fast_clock_tick,
    output logic             state_hold,
    output logic [4:0]       power_mode,
    // interrupt
    output logic             irq
);

    sysclk_pkg::state_s s_q;
    sysclk_pkg::state_s s_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a divided fast tick fires when the low bits of the shared chain are all ones
    function automatic logic src_tick(input logic [2:0] sel,
                                      input logic [5:0] cnt,
                                      input logic       fast_on,
                                      input logic       sub_t);
        logic [5:0] mask;
        mask = 6'h00;
        if (sel == `SEL_SUB_CODE) begin
            src_tick = sub_t;
        end else begin
            mask     = 6'((7'h01 << sel) - 7'h01);
            src_tick = fast_on && ((cnt & mask) == mask);
        end
    endfunction

    // a filtered level follows the pin only once the last two stages agree
    function automatic logic filt(input logic [2:0] sync, input logic level);
        filt = (sync[1] == sync[2]) ? sync[2] : level;
    endfunction

    // ------------------------------------------------------------
    // combinational next state
    // ------------------------------------------------------------
    logic       halted;
    logic       sub_tick;
    logic       fast_tick;
    logic       cur_tick;
    logic       tgt_tick;
    logic       tgt_ok;
    logic       mux_tick;
    logic       sys_on;
    logic       fast_on;
    logic       slow_on;
    logic       sub_on;
    logic       fast_en_rise;
    logic       addr_phase;
    logic [2:0] ev;
    logic [7:0] wb;

    always_comb begin
        s_d          = s_q;
        ev           = 3'h0;
        wb           = 8'h00;
        fast_en_rise = 1'b0;
        halted       = (s_q.mode != sysclk_pkg::MODE_RUN);

        // pin synchronisers, first stage feeds only the second
        s_d.fast_rdy_sync  = {s_q.fast_rdy_sync[1:0], fast_osc_ready};
        s_d.slow_rdy_sync  = {s_q.slow_rdy_sync[1:0], slow_osc_ready};
        s_d.slow_clk_sync  = {s_q.slow_clk_sync[1:0], slow_osc_clk};
        s_d.fast_rdy_level = filt(s_q.fast_rdy_sync, s_q.fast_rdy_level);
        s_d.slow_rdy_level = filt(s_q.slow_rdy_sync, s_q.slow_rdy_level);
        s_d.slow_clk_level = filt(s_q.slow_clk_sync, s_q.slow_clk_level);

        // oscillator and clock enables per power mode
        fast_on = 1'b0;
        slow_on = 1'b0;
        sub_on  = 1'b0;
        sys_on  = 1'b0;
        case (s_q.mode)
            sysclk_pkg::MODE_RUN: begin
                // fast keeps running while it feeds or is about to feed the cpu
                fast_on = s_q.fast_osc_enable
                       || (s_q.active_select != `SEL_SUB_CODE)
                       || (s_q.sysclk_select != `SEL_SUB_CODE);
                slow_on = 1'b1;
                sub_on  = 1'b1;
                sys_on  = 1'b1;
            end
            sysclk_pkg::MODE_SLEEP: begin
                slow_on = wdt_enable;
            end
            sysclk_pkg::MODE_IDLE_SLOW_ONLY: begin
                slow_on = 1'b1;
                sub_on  = 1'b1;
                sys_on  = (s_q.active_select == `SEL_SUB_CODE);
            end
            sysclk_pkg::MODE_IDLE_BOTH_OSC: begin
                fast_on = 1'b1;
                slow_on = 1'b1;
                sub_on  = 1'b1;
                sys_on  = 1'b1;
            end
            sysclk_pkg::MODE_IDLE_FAST_ONLY: begin
                fast_on = 1'b1;
                slow_on = 1'b1;
                sys_on  = (s_q.active_select != `SEL_SUB_CODE);
            end
            default: begin
                fast_on = 1'b0;
            end
        endcase

        // sub clock ticks on each filtered rising edge of the slow oscillator while sub_on is high
        sub_tick  = sub_on && slow_on && s_d.slow_clk_level && !s_q.slow_clk_level;
        fast_tick = fast_on;

        // single free running chain, every divided tick derives from it
        if (fast_on) begin
            s_d.div_count = s_q.div_count + 6'h01;
        end

        // glitch free mux: finish the current period, then wait for an aligned
        // target edge; the output is silent in between so no runt tick exists
        cur_tick = src_tick(s_q.active_select, s_q.div_count, fast_on, sub_tick);
        tgt_tick = src_tick(s_q.sysclk_select, s_q.div_count, fast_on, sub_tick);
        tgt_ok   = (s_q.sysclk_select == `SEL_SUB_CODE) ? s_q.slow_rdy_level
                                                         : fast_on;
        mux_tick = 1'b0;
        case (s_q.sw_state)
            sysclk_pkg::SW_RUN: begin
                mux_tick = cur_tick;
                if (!halted && s_q.sysclk_select != s_q.active_select) begin
                    s_d.sw_state = sysclk_pkg::SW_DRAIN;
                end
            end
            sysclk_pkg::SW_DRAIN: begin
                mux_tick = cur_tick;
                if (cur_tick) begin
                    s_d.sw_state = sysclk_pkg::SW_ALIGN;
                end
            end
            sysclk_pkg::SW_ALIGN: begin
                if (tgt_ok && tgt_tick) begin
                    mux_tick          = 1'b1;
                    s_d.active_select = s_q.sysclk_select;
                    s_d.sw_state      = sysclk_pkg::SW_RUN;
                    ev[`IRQ_SWITCH_DONE_BIT] = 1'b1;
                end
            end
            default: begin
                s_d.sw_state = sysclk_pkg::SW_RUN;
            end
        endcase

        // halt is taken only with the mux settled; keep bits pick the mode
        if (!halted && halt_exec && s_q.sw_state == sysclk_pkg::SW_RUN) begin
            ev[`IRQ_HALT_ENTER_BIT] = 1'b1;
            case ({s_q.halt_fast_osc_keep, s_q.halt_slow_osc_keep})
                2'b00:   s_d.mode = sysclk_pkg::MODE_SLEEP;
                2'b01:   s_d.mode = sysclk_pkg::MODE_IDLE_SLOW_ONLY;
                2'b11:   s_d.mode = sysclk_pkg::MODE_IDLE_BOTH_OSC;
                default: s_d.mode = sysclk_pkg::MODE_IDLE_FAST_ONLY;
            endcase
        end else if (halted && wake_req) begin
            s_d.mode = sysclk_pkg::MODE_RUN;
        end

        // ------------------------------------------------------------
        // ahb-lite slave: writes are zero wait, reads take one wait state
        // so that a read right after a write sees the written value
        // ------------------------------------------------------------
        addr_phase  = hsel && htrans[1] && hready;
        s_d.rd_pend = 1'b0;
        if (s_q.wr_pend) begin
            s_d.wr_pend = 1'b0;
            wb          = hwdata[7:0];
            if (s_q.addr == `SYSCLK_CTRL_ADDR) begin
                s_d.sysclk_select      = wb[`SEL_MSB:`SEL_LSB];
                s_d.halt_fast_osc_keep = wb[`HALT_FAST_KEEP_BIT];
                s_d.halt_slow_osc_keep = wb[`HALT_SLOW_KEEP_BIT];
            end else if (s_q.addr == `FAST_OSC_CTRL_ADDR) begin
                s_d.fast_osc_enable = wb[`FAST_ENABLE_BIT];
                fast_en_rise        = wb[`FAST_ENABLE_BIT] && !s_q.fast_osc_enable;
            end else if (s_q.addr == `IRQ_CLEAR_ADDR) begin
                s_d.irq_status = s_q.irq_status & ~wb[2:0];
            end else if (s_q.addr == `IRQ_ENABLE_ADDR) begin
                s_d.irq_enable = wb[2:0];
            end
        end else if (s_q.rd_pend) begin
            s_d.hrdata = 32'h0000_0000;
            if (s_q.addr == `SYSCLK_CTRL_ADDR) begin
                s_d.hrdata[`SEL_MSB:`SEL_LSB]   = s_q.sysclk_select;
                s_d.hrdata[`HALT_FAST_KEEP_BIT] = s_q.halt_fast_osc_keep;
                s_d.hrdata[`HALT_SLOW_KEEP_BIT] = s_q.halt_slow_osc_keep;
            end else if (s_q.addr == `FAST_OSC_CTRL_ADDR) begin
                s_d.hrdata[`FAST_STABLE_BIT] = s_q.fast_osc_stable_flag;
                s_d.hrdata[`FAST_ENABLE_BIT] = s_q.fast_osc_enable;
            end else if (s_q.addr == `IRQ_STATUS_ADDR) begin
                s_d.hrdata[2:0] = s_q.irq_status;
            end else if (s_q.addr == `IRQ_ENABLE_ADDR) begin
                s_d.hrdata[2:0] = s_q.irq_enable;
            end
        end
        if (addr_phase) begin
            s_d.addr    = haddr;
            s_d.wr_pend = hwrite;
            s_d.rd_pend = !hwrite;
        end

        // stable flag: cleared on the enabling write, set when the pin settles
        if (fast_en_rise || !fast_on) begin
            s_d.fast_osc_stable_flag = 1'b0;
        end else if (s_q.fast_rdy_level) begin
            s_d.fast_osc_stable_flag = 1'b1;
        end
        ev[`IRQ_FAST_STABLE_BIT] = s_d.fast_osc_stable_flag && !s_q.fast_osc_stable_flag;

        // sticky events; a set in the clearing cycle wins
        s_d.irq_status = s_d.irq_status | ev;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q                      <= '0;
            s_q.sysclk_select        <= `SEL_RESET;
            s_q.halt_fast_osc_keep   <= `FAST_KEEP_RESET;
            s_q.halt_slow_osc_keep   <= `SLOW_KEEP_RESET;
            s_q.fast_osc_enable      <= `FAST_ENABLE_RESET;
            s_q.active_select        <= `SEL_RESET;
            s_q.mode                 <= sysclk_pkg::MODE_RUN;
            s_q.sw_state             <= sysclk_pkg::SW_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout         = !s_q.rd_pend;
    assign hresp             = 1'b0;
    assign hrdata            = s_q.hrdata;
    assign fast_osc_run      = fast_on;
    assign slow_osc_run      = slow_on;
    assign cpu_run           = !halted;
    assign system_clock_tick = sys_on && mux_tick;
    assign sub_clock_tick    = sub_tick;
    assign fast_clock_tick   = fast_tick;
    // core logic freezes its storage and port drivers while this is high
    assign state_hold        = halted;
    assign power_mode        = s_q.mode;
    assign irq               = |(s_q.irq_status & s_q.irq_enable);

endmodule // system_clock_mode_control

// ### test/sysclk_mode_checker.sv
`timescale 1ns/1ps
// ------------------------------------
// power mode and bus checks
// ------------------------------------
module sysclk_mode_checker (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // events and clocks
    input wire logic       halt_exec,
    input wire logic       wake_req,
    input wire logic       wdt_enable,
    input wire logic       fast_osc_run,
    input wire logic       slow_osc_run,
    input wire logic       cpu_run,
    input wire logic       system_clock_tick,
    input wire logic       sub_clock_tick,
    input wire logic       fast_clock_tick,
    input wire logic       state_hold,
    input wire logic [4:0] power_mode
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_take;
        hsel && htrans[1] && !hwrite && hready;
    endsequence
    sequence rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    read_wait_a: assert property (rd_take |=> rd_wait)
        else $error("read did not take one wait state");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    sleep_stop_a: assert property (power_mode == sysclk_pkg::MODE_SLEEP
        |-> !cpu_run && !sub_clock_tick && !system_clock_tick)
        else $error("sleep left a clock running");
    sleep_slow_a: assert property (power_mode == sysclk_pkg::MODE_SLEEP
        |-> slow_osc_run == wdt_enable)
        else $error("slow oscillator does not follow watchdog in sleep");
    idle_slow_a: assert property (power_mode == sysclk_pkg::MODE_IDLE_SLOW_ONLY
        |-> !cpu_run && !fast_osc_run && slow_osc_run)
        else $error("wrong oscillators in slow-only idle");
    idle_both_a: assert property (power_mode == sysclk_pkg::MODE_IDLE_BOTH_OSC
        |-> !cpu_run && fast_osc_run && slow_osc_run)
        else $error("wrong oscillators in both-osc idle");
    idle_fast_a: assert property (power_mode == sysclk_pkg::MODE_IDLE_FAST_ONLY
        |-> !cpu_run && fast_osc_run && !sub_clock_tick)
        else $error("wrong clocks in fast-only idle");
    // with the fast oscillator stopped, every system tick must be a sub clock tick
    fast_tick_a: assert property (fast_clock_tick == fast_osc_run
        && (fast_osc_run || !system_clock_tick || sub_clock_tick))
        else $error("fast clock or system clock source wrong with fast oscillator off");
    halt_enter_a: assert property ($rose(state_hold)
        |-> $past(halt_exec) && $past(cpu_run))
        else $error("halt entered without a halt request");
    wake_leave_a: assert property ($fell(state_hold) |-> $past(wake_req) && cpu_run)
        else $error("halt left without a wake request");
    hold_mode_a: assert property (state_hold
        |-> !cpu_run && power_mode != sysclk_pkg::MODE_RUN)
        else $error("hold without a halt mode");
endmodule // sysclk_mode_checker

bind system_clock_mode_control sysclk_mode_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .halt_exec(halt_exec),
    .wake_req(wake_req), .wdt_enable(wdt_enable), .fast_osc_run(fast_osc_run),
    .slow_osc_run(slow_osc_run), .cpu_run(cpu_run), .system_clock_tick(system_clock_tick),
    .sub_clock_tick(sub_clock_tick), .fast_clock_tick(fast_clock_tick),
    .state_hold(state_hold), .power_mode(power_mode));

// ### test/system_clock_mode_control_test.sv
`timescale 1ns/1ps
`include "sysclk_consts.svh"
module system_clock_mode_control_test;
    // ------------------------------------
    // pins and oscillator stand-ins
    // ------------------------------------
    localparam int SLOW_HALF = 10;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        halt_exec = 1'b0, wake_req = 1'b0, wdt_enable = 1'b0;
    logic        fast_osc_ready = 1'b0, slow_osc_ready = 1'b0, slow_osc_clk = 1'b0;
    logic        slow_block = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, r;
    logic [4:0]  fast_dly = 5'h00, slow_dly = 5'h00, power_mode;
    logic        hreadyout, hresp, fast_osc_run, slow_osc_run, cpu_run, irq;
    logic        system_clock_tick, sub_clock_tick, fast_clock_tick, state_hold;
    int          osc_cnt = 0, error_cnt = 0, n_tests = 0, cyc, g, ns, nb, p;
    logic [1:0]  kp [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h0};
    sysclk_pkg::mode_e md [5] = '{sysclk_pkg::MODE_IDLE_SLOW_ONLY,
        sysclk_pkg::MODE_IDLE_BOTH_OSC, sysclk_pkg::MODE_IDLE_FAST_ONLY,
        sysclk_pkg::MODE_SLEEP, sysclk_pkg::MODE_SLEEP};

    always #2 hclk = ~hclk;
    // ready drops two clocks after stop, rises six clocks after start
    always @(posedge hclk) begin
        fast_dly <= {fast_dly[3:0], fast_osc_run};
        slow_dly <= {slow_dly[3:0], slow_osc_run};
        fast_osc_ready <= &fast_dly;
        // slow_block keeps the slow oscillator unsettled to exercise the switch guard
        slow_osc_ready <= &slow_dly && !slow_block;
        osc_cnt <= (osc_cnt == 2 * SLOW_HALF - 1) ? 0 : osc_cnt + 1;
        slow_osc_clk <= slow_osc_run && (osc_cnt >= SLOW_HALF);
    end

    system_clock_mode_control uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .halt_exec(halt_exec),
        .wake_req(wake_req), .wdt_enable(wdt_enable), .fast_osc_ready(fast_osc_ready),
        .slow_osc_ready(slow_osc_ready), .slow_osc_clk(slow_osc_clk),
        .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run), .cpu_run(cpu_run),
        .system_clock_tick(system_clock_tick), .sub_clock_tick(sub_clock_tick),
        .fast_clock_tick(fast_clock_tick), .state_hold(state_hold),
        .power_mode(power_mode), .irq(irq));

    // ------------------------------------
    // bus and compare tasks
    // ------------------------------------
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(r, exp);
    endtask
    // polls the done flag, so the measured time carries some bus slack
    task automatic do_switch(input logic [2:0] s);
        xfer(`IRQ_CLEAR_ADDR, 1'b1, 32'h7);
        @(posedge hclk);
        chk(irq, 1'b0);
        cyc = 0;
        xfer(`SYSCLK_CTRL_ADDR, 1'b1, {24'h0, s, 5'h00});
        do begin
            xfer(`IRQ_STATUS_ADDR, 1'b0, 32'h0);
            cyc += 4;
        end while (r[0] !== 1'b1);
    endtask
    function automatic int per(input int c);
        return (c == 7) ? 2 * SLOW_HALF : 1 << c;
    endfunction
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------
    // tests
    // ------------------------------------
    initial begin
        repeat (40000) @(posedge hclk);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
        rd_chk(`SYSCLK_CTRL_ADDR, 32'h0);
        rd_chk(`FAST_OSC_CTRL_ADDR, 32'h3);
        xfer(`SYSCLK_CTRL_ADDR, 1'b1, 32'hFFFFFF1F);
        rd_chk(`SYSCLK_CTRL_ADDR, 32'h3);
        xfer(`FAST_OSC_CTRL_ADDR, 1'b1, 32'hFFFFFFFC);
        rd_chk(`FAST_OSC_CTRL_ADDR, 32'h2);
        xfer(`FAST_OSC_CTRL_ADDR, 1'b1, 32'h1);
        rd_chk(8'h14, 32'h0);
        xfer(`IRQ_ENABLE_ADDR, 1'b1, 32'h1);
        rd_chk(`IRQ_ENABLE_ADDR, 32'h1);
        $display("registers done");
        p = 0;
        for (int k = 1; k <= 8; k++) begin
            do_switch(k[2:0]);
            chk(cyc <= 4 * per(p) + (3 * per(p) + per(k % 8)) / 2 + 16, 1'b1);
            chk(irq, 1'b1);
            g = 0;
            do @(posedge hclk); while (system_clock_tick !== 1'b1);
            do begin
                @(posedge hclk);
                g++;
            end while (system_clock_tick !== 1'b1);
            chk(g, per(k % 8));
            p = k % 8;
        end
        xfer(`IRQ_ENABLE_ADDR, 1'b1, 32'h0);
        // slow oscillator held unsettled: the switch to the sub clock must not finish
        xfer(`IRQ_CLEAR_ADDR, 1'b1, 32'h7);
        slow_block <= 1'b1;
        repeat (8) @(posedge hclk);
        xfer(`SYSCLK_CTRL_ADDR, 1'b1, 32'hE0);
        repeat (120) @(posedge hclk);
        rd_chk(`IRQ_STATUS_ADDR, 32'h0);
        slow_block <= 1'b0;
        do_switch(3'h7);
        chk(irq, 1'b0);
        $display("clock select done");
        xfer(`FAST_OSC_CTRL_ADDR, 1'b1, 32'h0);
        repeat (10) @(posedge hclk);
        chk(fast_osc_run, 1'b0);
        rd_chk(`FAST_OSC_CTRL_ADDR, 32'h0);
        xfer(`FAST_OSC_CTRL_ADDR, 1'b1, 32'h1);
        rd_chk(`FAST_OSC_CTRL_ADDR, 32'h1);
        repeat (12) @(posedge hclk);
        rd_chk(`FAST_OSC_CTRL_ADDR, 32'h3);
        $display("fast oscillator done");
        for (int i = 0; i < 5; i++) begin
            wdt_enable <= (i == 4);
            xfer(`SYSCLK_CTRL_ADDR, 1'b1, {24'h0, 6'h38, kp[i]});
            @(posedge hclk);
            halt_exec <= 1'b1;
            @(posedge hclk);
            halt_exec <= 1'b0;
            @(posedge hclk);
            chk(power_mode, md[i]);
            chk({cpu_run, state_hold}, 2'h1);
            chk(fast_osc_run, kp[i][1]);
            chk(slow_osc_run, (kp[i] != 2'h0) || (i == 4));
            ns = 0;
            nb = 0;
            repeat (60) begin
                @(posedge hclk);
                ns += (system_clock_tick === 1'b1);
                nb += (sub_clock_tick === 1'b1);
            end
            chk({ns != 0, nb != 0}, {2{kp[i][0]}});
            rd_chk(`SYSCLK_CTRL_ADDR, {24'h0, 6'h38, kp[i]});
            wake_req <= 1'b1;
            @(posedge hclk);
            wake_req <= 1'b0;
            @(posedge hclk);
            @(posedge hclk);
            chk(cpu_run, 1'b1);
        end
        $display("halt modes done");
        final_report();
    end
endmodule // system_clock_mode_control_test
